// ---- src/ubx_transceiver.v ----
`timescale 1ns/1ps
`include "ubx_map.vh"

// Notes on behaviour
// - 36 bits either way, latch or flop
// - Latch enable high: A passes to B
// - Latch enable low, clock steady: B holds
// - Clock rising with latch low captures A
// - B-to-A path works the same way
// - B driven only while A-to-B enable high
// - A driven while B-to-A enable low, and for three cycles just after reset release
module ubx_transceiver (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // A port pins
    input wire [`UBX_WIDTH-1:0] a_in,
    output wire [`UBX_WIDTH-1:0] a_out,
    output wire a_oe,
    // B port pins
    input wire [`UBX_WIDTH-1:0] b_in,
    output wire [`UBX_WIDTH-1:0] b_out,
    output wire b_oe,
    // A-to-B controls
    input wire a_to_b_output_enable,
    input wire a_to_b_latch_enable,
    input wire a_to_b_clock,
    // B-to-A controls
    input wire b_to_a_output_enable_n,
    input wire b_to_a_latch_enable,
    input wire b_to_a_clock
);

    // Reset release pipe, two flops deep
    reg [1:0] rst_pipe;
    // Synchronised reset, active low; every other process uses it
    wire sys_rst_n;

    // Release reset through two flops; assertion stays asynchronous
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Hold the pipe cleared while the pin is low
            rst_pipe <= `UBX_RST_PIPE_RESET;
        end else begin
            // Shift ones in so release lands two edges later
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // Only the second flop of the pipe drives the reset tree
    assign sys_rst_n = rst_pipe[1];

    // Control pins gathered at their field positions
    wire [`UBX_CTL_WIDTH-1:0] ctl_pins;

    // Order follows the position macros, highest bit first
    assign ctl_pins = {b_to_a_clock, b_to_a_latch_enable,
                       b_to_a_output_enable_n, a_to_b_clock,
                       a_to_b_latch_enable, a_to_b_output_enable};

    // A pin synchroniser, stage one (metastability catcher)
    reg [`UBX_WIDTH-1:0] a_s1;
    // A pin synchroniser, stage two
    reg [`UBX_WIDTH-1:0] a_s2;
    // A pin synchroniser, stage three
    reg [`UBX_WIDTH-1:0] a_s3;
    // B pin synchroniser, stage one
    reg [`UBX_WIDTH-1:0] b_s1;
    // B pin synchroniser, stage two
    reg [`UBX_WIDTH-1:0] b_s2;
    // B pin synchroniser, stage three
    reg [`UBX_WIDTH-1:0] b_s3;
    // Control synchroniser, stage one
    reg [`UBX_CTL_WIDTH-1:0] c_s1;
    // Control synchroniser, stage two
    reg [`UBX_CTL_WIDTH-1:0] c_s2;
    // Control synchroniser, stage three
    reg [`UBX_CTL_WIDTH-1:0] c_s3;

    // A pins pass a three-flop chain; the filter looks at stages two and three
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            a_s1 <= `UBX_STORE_RESET;
            a_s2 <= `UBX_STORE_RESET;
            a_s3 <= `UBX_STORE_RESET;
        end else begin
            a_s1 <= a_in;
            a_s2 <= a_s1;
            a_s3 <= a_s2;
        end
    end

    // B pins: the same three-flop chain
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            b_s1 <= `UBX_STORE_RESET;
            b_s2 <= `UBX_STORE_RESET;
            b_s3 <= `UBX_STORE_RESET;
        end else begin
            b_s1 <= b_in;
            b_s2 <= b_s1;
            b_s3 <= b_s2;
        end
    end

    // Control pins: the same chain, all six levels together
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            c_s1 <= `UBX_CTL_STAGE_RESET;
            c_s2 <= `UBX_CTL_STAGE_RESET;
            c_s3 <= `UBX_CTL_STAGE_RESET;
        end else begin
            c_s1 <= ctl_pins;
            c_s2 <= c_s1;
            c_s3 <= c_s2;
        end
    end

    // Accept a data bit change only once stages two and three agree;
    // while they differ the bit keeps its previous filtered level
    function [`UBX_WIDTH-1:0] agree;
        input [`UBX_WIDTH-1:0] s2;
        input [`UBX_WIDTH-1:0] s3;
        input [`UBX_WIDTH-1:0] held;
        begin
            agree = (s2 & s3) | (held & (s2 | s3));
        end
    endfunction

    // Same vote for the six control levels
    function [`UBX_CTL_WIDTH-1:0] agree_ctl;
        input [`UBX_CTL_WIDTH-1:0] s2;
        input [`UBX_CTL_WIDTH-1:0] s3;
        input [`UBX_CTL_WIDTH-1:0] held;
        begin
            agree_ctl = (s2 & s3) | (held & (s2 | s3));
        end
    endfunction

    // Rising edge of a filtered clock level, ignored until settled
    function rising;
        input cur;
        input prev;
        input live;
        begin
            rising = live & cur & ~prev;
        end
    endfunction

    // Filtered control levels
    reg [`UBX_CTL_WIDTH-1:0] ctl;
    // Filtered A pin levels
    reg [`UBX_WIDTH-1:0] a_val;
    // Filtered B pin levels
    reg [`UBX_WIDTH-1:0] b_val;

    // Filtered levels; controls start with both outputs off
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            // Output enables read as off in reset; the cleared stages then turn a_oe on until the pins are seen
            ctl <= `UBX_CTL_RESET;
            a_val <= `UBX_STORE_RESET;
            b_val <= `UBX_STORE_RESET;
        end else begin
            ctl <= agree_ctl(c_s2, c_s3, ctl);
            a_val <= agree(a_s2, a_s3, a_val);
            b_val <= agree(b_s2, b_s3, b_val);
        end
    end

    // Cycles since release; edges count only once the filter is full
    reg [2:0] settle;
    // High once the filtered clock levels are trustworthy
    wire edges_live;

    // Count up to the settle figure and stop there
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            settle <= `UBX_SETTLE_RESET;
        end else if (!edges_live) begin
            // Still filling the synchroniser chains
            settle <= settle + 3'h1;
        end else begin
            // Saturated: keep the count
            settle <= settle;
        end
    end

    // Avoids a false capture when a clock pin idles high at reset
    assign edges_live = (settle == `UBX_SETTLE_CYCLES);

    // Previous A-to-B clock level
    reg ab_clk_d;
    // Previous B-to-A clock level
    reg ba_clk_d;
    // A-to-B storage, one latch/flop per bit
    reg [`UBX_WIDTH-1:0] ab_store;
    // B-to-A storage, one latch/flop per bit
    reg [`UBX_WIDTH-1:0] ba_store;
    // Rising edge of the A-to-B clock
    wire ab_rise;
    // Rising edge of the B-to-A clock
    wire ba_rise;

    assign ab_rise = rising(ctl[`UBX_CTL_AB_CLK], ab_clk_d, edges_live);
    assign ba_rise = rising(ctl[`UBX_CTL_BA_CLK], ba_clk_d, edges_live);

    // Remember the clock levels for edge detection
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ab_clk_d <= `UBX_EDGE_RESET;
            ba_clk_d <= `UBX_EDGE_RESET;
        end else begin
            ab_clk_d <= ctl[`UBX_CTL_AB_CLK];
            ba_clk_d <= ctl[`UBX_CTL_BA_CLK];
        end
    end

    // A-to-B storage; runs whatever the output enable says
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ab_store <= `UBX_STORE_RESET;
        end else if (ctl[`UBX_CTL_AB_LE]) begin
            // Transparent: follow the A pins
            ab_store <= a_val;
        end else if (ab_rise) begin
            // Latch closed, clock rose: capture the A pins
            ab_store <= a_val;
        end else begin
            // Latch closed, clock steady: hold
            ab_store <= ab_store;
        end
    end

    // B-to-A storage on its own controls only
    always @(posedge clock or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ba_store <= `UBX_STORE_RESET;
        end else if (ctl[`UBX_CTL_BA_LE]) begin
            // Transparent: follow the B pins
            ba_store <= b_val;
        end else if (ba_rise) begin
            // Latch closed, clock rose: capture the B pins
            ba_store <= b_val;
        end else begin
            // Latch closed, clock steady: hold
            ba_store <= ba_store;
        end
    end

    // Driven values come straight from the storage flops
    assign b_out = ab_store;
    assign a_out = ba_store;

    // B pins driven while the A-to-B enable is high
    assign b_oe = ctl[`UBX_CTL_AB_OE];
    // A pins driven while the active-low B-to-A enable is low
    assign a_oe = ~ctl[`UBX_CTL_BA_OEN];

endmodule

// ---- inc/ubx_map.vh ----
`ifndef UBX_MAP_VH
`define UBX_MAP_VH

// Data path width of each port
`define UBX_WIDTH 36
// Synchroniser depth for pin inputs
`define UBX_SYNC_DEPTH 3
// Reset value of the storage elements
`define UBX_STORE_RESET 36'h000000000
// Reset value of the reset release pipe
`define UBX_RST_PIPE_RESET 2'h0
// Number of gathered control levels
`define UBX_CTL_WIDTH 6
// Reset value of the control synchroniser stages
`define UBX_CTL_STAGE_RESET 6'h00
// Reset value of the filtered controls: both outputs off
`define UBX_CTL_RESET 6'h08
// Reset value of the previous clock levels
`define UBX_EDGE_RESET 1'b0
// Reset value of the settle counter
`define UBX_SETTLE_RESET 3'h0
// Cycles after release before clock edges are believed
`define UBX_SETTLE_CYCLES 3'h5
// Field positions within the gathered controls
`define UBX_CTL_AB_OE 0
`define UBX_CTL_AB_LE 1
`define UBX_CTL_AB_CLK 2
`define UBX_CTL_BA_OEN 3
`define UBX_CTL_BA_LE 4
`define UBX_CTL_BA_CLK 5

`endif

// ---- tb/ubx_chk_asserts.sv ----
`timescale 1ns/1ps
// Checks pin behaviour once the input filters have settled
module ubx_chk(input wire clock, rst_n, a_oe, b_oe, a_to_b_output_enable,
 a_to_b_latch_enable, a_to_b_clock, b_to_a_output_enable_n,
 b_to_a_latch_enable, b_to_a_clock, input wire [35:0] a_in, a_out, b_in,
 b_out);
reg [3:0] up; // Cycles since reset, saturating
wire r = &up, ea = a_to_b_output_enable, eb = b_to_a_output_enable_n;
wire la = a_to_b_latch_enable, lb = b_to_a_latch_enable;
wire ca = a_to_b_clock, cb = b_to_a_clock;
// Masks the reset release pipe
always @(posedge clock or negedge rst_n) up <= rst_n ? up+{3'h0,!r} : 4'h0;
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
a_en_ab: assert property ((r&&$stable(ea))[*8] |-> b_oe==ea)
 else $error("b_oe");
a_en_ba: assert property ((r&&$stable(eb))[*8] |-> a_oe!=eb)
 else $error("a_oe");
a_pass_ab: assert property ((r&&la&&$stable(a_in))[*8]
 |-> b_out==a_in) else $error("pass");
a_pass_ba: assert property ((r&&lb&&$stable(b_in))[*8]
 |-> a_out==b_in) else $error("bpass");
a_hold_ab: assert property ((r&&!la&&$stable(ca))[*8]
 |-> $stable(b_out)) else $error("hold");
a_hold_ba: assert property ((r&&!lb&&$stable(cb))[*8]
 |-> $stable(a_out)) else $error("bhold");
a_cap_ab: assert property ((r&&!la&&!ca)[*4] ##1 (!la&&$rose(ca))
 ##1 (!la&&ca&&$stable(a_in))[*6] |-> b_out==a_in) else $error("capt");
a_cap_ba: assert property ((r&&!lb&&!cb)[*4] ##1 (!lb&&$rose(cb))
 ##1 (!lb&&cb&&$stable(b_in))[*6] |-> a_out==b_in) else $error("bcapt");
a_keep_ab: assert property ((r&&la&&$stable(a_in))[*8]
 ##0 $rose(b_oe) |-> b_out==a_in) else $error("keep");
cover property ($rose(b_oe));
cover property ($rose(a_oe));
cover property (!la && $rose(ca));
endmodule
bind ubx_transceiver ubx_chk ubx_chk_inst(.*);

// ---- tb/ubx_bus.sv ----
`timescale 1ns/1ps
// Bus logic on both sides; it lets go of a side the device drives
module ubx_bus(input wire a_oe, b_oe, input wire [35:0] a_out, b_out, a_drv,
 b_drv, output wire [35:0] a_in, b_in);
assign a_in = a_oe ? a_out : a_drv;
assign b_in = b_oe ? b_out : b_drv;
endmodule

// ---- tb/tb_ubx_transceiver.sv ----
`timescale 1ns/1ps
module tb_ubx_transceiver;
reg clock = 0, rst_n = 0, ea = 0, la = 0, ca = 0, eb = 1, lb = 0, cb = 0;
reg [35:0] a_drv = 36'h0, b_drv = 36'h0;
wire [35:0] a_in, b_in, a_out, b_out;
wire a_oe, b_oe;
integer fail_count = 0, n_tests = 0, cyc = 0;
always #4 clock = ~clock;
ubx_transceiver ubx_transceiver_inst(.*, .a_to_b_output_enable(ea),
 .a_to_b_latch_enable(la), .a_to_b_clock(ca), .b_to_a_output_enable_n(eb),
 .b_to_a_latch_enable(lb), .b_to_a_clock(cb));
ubx_bus ubx_bus_inst(.*);
task chk(input [39:0] nm, input [35:0] s, e); begin
    n_tests = n_tests + 1;
    if (s !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch %s exp %h seen %h", nm, e, s);
    end
end endtask
task test_done; begin
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
end endtask
// Long enough for the input filter and the latency
task w; repeat (10) @(posedge clock); endtask
// Cuts a hang short
always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin fail_count = fail_count + 1; test_done; end
end
// A to B: pass, hold with clock low first, then capture
task t_ab; begin
    ea <= 1; la <= 1; a_drv <= 36'hA5A5A5A5A; w;
    chk("pass", b_out, 36'hA5A5A5A5A);
    chk("b_oe", {35'h0, b_oe}, 36'h1);
    chk("a_off", {35'h0, a_oe}, 36'h0);
    la <= 0; w; a_drv <= 36'h123456789; w;
    chk("hold", b_out, 36'hA5A5A5A5A);
    ca <= 1; w;
    chk("capt", b_out, 36'h123456789);
    a_drv <= 36'h0; w;
    chk("holdh", b_out, 36'h123456789);
end endtask
// Storage follows while B is floated
task t_off; begin
    ea <= 0; la <= 1; a_drv <= 36'h0F0F0F0F0; w;
    chk("b_off", {35'h0, b_oe}, 36'h0);
    ea <= 1; w;
    chk("keep", b_out, 36'h0F0F0F0F0);
end endtask
// B to A: pass, hold, capture
task t_ba; begin
    ea <= 0; eb <= 0; lb <= 1; b_drv <= 36'hFEDCBA987; w;
    chk("a_oe", {35'h0, a_oe}, 36'h1);
    chk("bpass", a_out, 36'hFEDCBA987);
    lb <= 0; w; b_drv <= 36'h111111111; w;
    chk("bhold", a_out, 36'hFEDCBA987);
    cb <= 1; w;
    chk("bcapt", a_out, 36'h111111111);
end endtask
initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    w;
    t_ab;
    t_off;
    t_ba;
    test_done;
end
endmodule
